// [src/lst_pkg.sv]
// package for the link controller self-test sequencer
// assumes one 200 MHz clock domain and an Avalon-MM register bus
package lst_pkg;
	localparam int unsigned ADDR_W = 4;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_PRIM_CMD = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_BUS_CTRL = 4'h8;
	// field positions
	localparam int unsigned FAIL_BIT    = 4;
	localparam int unsigned AVAIL_BIT   = 6;
	localparam int unsigned TEST_EN_BIT = 4;
	localparam int unsigned USER_PRIMITIVE_CODE_LSB   = 8;
	localparam int unsigned CODE_W      = 4;
	localparam int unsigned PROVIDER_PRIMITIVE_CODE_LSB   = 0;
	localparam logic [CODE_W-1:0] USER_PRIMITIVE_CODE_SELF_TEST = 4'h5;
	localparam logic [15:0] CLEAR_AVAIL_VAL = 16'h0040;
	// result codes
	localparam logic [CODE_W-1:0] RES_PASS  = 4'h0;
	localparam logic [CODE_W-1:0] RES_RESET = 4'h1;
	localparam logic [CODE_W-1:0] RES_RAM   = 4'h2;
	localparam logic [CODE_W-1:0] RES_ALU   = 4'h3;
	localparam logic [CODE_W-1:0] RES_TIMER = 4'h4;
	localparam logic [CODE_W-1:0] RES_TXRX  = 4'h5;
	localparam logic [CODE_W-1:0] RES_REGS  = 4'h6;
	localparam logic [CODE_W-1:0] RES_DEV   = 4'h7;
	localparam int unsigned NUM_UNITS = 6;
	// timing
	localparam int unsigned CLK_MHZ      = 200;
	localparam int unsigned LIMIT_MS     = 75;
	localparam int unsigned REF_MHZ      = 10;
	localparam int unsigned LIMIT_CYCLES = LIMIT_MS * 1000 * REF_MHZ;
	localparam int unsigned UNIT_CYCLES  = 16;
	localparam logic [31:0] RESET_VAL    = 32'h0;
	typedef enum logic [2:0] {
		ST_IDLE, ST_RUN, ST_POST, ST_DONE
	} lst_state_t;
endpackage

// [src/lst_self_test.sv]
// self-test sequencer with its command and bus control registers
// assumes an Avalon-MM master on ref_clk; fault_inject is one pin per unit
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lst_self_test
	import lst_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = LIMIT_CYCLES * CLK_MHZ / REF_MHZ
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	output logic [1:0]             avs_response,
	// test pins
	input  wire logic [NUM_UNITS-1:0] fault_inject,
	output logic                   test_busy
);
	lst_state_t           state_ff;
	lst_state_t           nxt_state;
	logic [15:0]          bus_ctrl_ff;
	logic [15:0]          nxt_bus_ctrl;
	logic                 avail_ff;
	logic                 nxt_avail;
	logic                 fail_ff;
	logic                 nxt_fail;
	logic [CODE_W-1:0]    code_ff;
	logic [CODE_W-1:0]    nxt_code;
	logic [2:0]           unit_ff;
	logic [2:0]           nxt_unit;
	logic                 u_start_pend;
	logic                 nxt_pend;
	logic [31:0]          tmo_ff;
	logic [31:0]          nxt_tmo;
	logic                 busy_ff;
	logic                 nxt_busy;
	logic                 ack_ff;
	logic                 nxt_ack;
	logic [31:0]          rdata_ff;
	logic [31:0]          nxt_rdata;
	logic [1:0]           resp_ff;
	logic [1:0]           nxt_resp;
	logic [NUM_UNITS-1:0] fi_s1_ff;
	logic [NUM_UNITS-1:0] fi_s2_ff;
	logic [NUM_UNITS-1:0] u_start;
	logic [NUM_UNITS-1:0] u_done;
	logic [NUM_UNITS-1:0] u_ok;
	logic                 req;
	logic                 wr_cmd;
	logic                 wr_bus;
	logic                 hit;
	logic [15:0]          wdata16;

	// address decode, shared by the bus and register logic
	function automatic logic is_cmd(input logic [ADDR_W-1:0] a);
		is_cmd = (a == OFS_PRIM_CMD);
	endfunction
	function automatic logic is_bus(input logic [ADDR_W-1:0] a);
		is_bus = (a == OFS_BUS_CTRL);
	endfunction

	// pins pass two flops before use
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			fi_s1_ff <= '0;
			fi_s2_ff <= '0;
		end else begin
			fi_s1_ff <= fault_inject;
			fi_s2_ff <= fi_s1_ff;
		end
	end

	for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
		// pend lasts one cycle, so the pulse must not wait on the bus
		assign u_start[g] = (state_ff == ST_RUN) && (unit_ff == 3'(g)) && u_start_pend;
		lst_unit_check #(.SEED(16'h1d2b + 16'(g * 37))) u_chk (
			.ref_clk     (ref_clk),
			.reset_n     (reset_n),
			.start       (u_start[g]),
			.force_fault (fi_s2_ff[g]),
			.done        (u_done[g]),
			.ok          (u_ok[g])
		);
	end

	// a unit is started once on entry; pend drops after the pulse
	assign req     = avs_read || avs_write;
	assign hit     = is_cmd(avs_address) || is_bus(avs_address);
	assign wdata16 = avs_writedata[15:0];
	// writes land in the acked cycle, when waitrequest is low
	assign wr_cmd  = avs_write && ack_ff && is_cmd(avs_address) && &avs_byteenable[1:0];
	assign wr_bus  = avs_write && ack_ff && is_bus(avs_address);

	// bus side: one wait state, read data latched for the acked cycle
	always_comb begin
		nxt_ack   = 1'b0;
		nxt_rdata = rdata_ff;
		nxt_resp  = 2'b00;
		if (req && !ack_ff) begin
			nxt_ack   = 1'b1;
			nxt_resp  = hit ? 2'b00 : 2'b10;
			nxt_rdata = 32'h0;
			if (is_cmd(avs_address)) begin
				nxt_rdata[FAIL_BIT] = fail_ff;
				nxt_rdata[AVAIL_BIT] = avail_ff;
				nxt_rdata[PROVIDER_PRIMITIVE_CODE_LSB +: CODE_W] = code_ff;
			end else if (is_bus(avs_address)) begin
				nxt_rdata[15:0] = bus_ctrl_ff;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_ff   <= 1'b0;
			rdata_ff <= RESET_VAL;
			resp_ff  <= 2'b00;
		end else begin
			ack_ff   <= nxt_ack;
			rdata_ff <= nxt_rdata;
			resp_ff  <= nxt_resp;
		end
	end

	always_comb begin
		nxt_state    = state_ff;
		nxt_bus_ctrl = bus_ctrl_ff;
		nxt_avail    = avail_ff;
		nxt_fail     = fail_ff;
		nxt_code     = code_ff;
		nxt_unit     = unit_ff;
		nxt_pend     = u_start_pend;
		nxt_tmo      = tmo_ff;
		if (wr_bus) begin
			if (avs_byteenable[0]) nxt_bus_ctrl[7:0] = wdata16[7:0];
			if (avs_byteenable[1]) nxt_bus_ctrl[15:8] = wdata16[15:8];
		end
		unique case (state_ff)
			ST_IDLE: begin
				// start on code 5 in test mode
				if (wr_cmd && wdata16[USER_PRIMITIVE_CODE_LSB +: CODE_W] == USER_PRIMITIVE_CODE_SELF_TEST
					&& bus_ctrl_ff[TEST_EN_BIT] && !avail_ff) begin
					nxt_state = ST_RUN;
					nxt_unit  = 3'h0;
					nxt_pend  = 1'b1;
					nxt_tmo   = 32'h0;
				end
			end
			ST_RUN: begin
				nxt_tmo = tmo_ff + 32'h1;
				if (u_start_pend) begin
					nxt_pend = 1'b0;
				end else if (u_done[unit_ff]) begin
					// code is failing unit plus one
					if (!u_ok[unit_ff]) begin
						nxt_fail  = 1'b1;
						nxt_code  = CODE_W'(unit_ff) + RES_RESET;
						nxt_state = ST_POST;
					end else if (unit_ff == 3'(NUM_UNITS - 1)) begin
						nxt_fail  = 1'b0;
						nxt_code  = RES_PASS;
						nxt_state = ST_POST;
					end else begin
						nxt_unit = unit_ff + 3'h1;
						nxt_pend = 1'b1;
					end
				end
				// bound the run; overrun reports device failure
				if (tmo_ff >= TIMEOUT_CYCLES - 32'h2) begin
					nxt_fail  = 1'b1;
					nxt_code  = RES_DEV;
					nxt_state = ST_POST;
				end
			end
			ST_POST: begin
				nxt_avail = 1'b1;
				nxt_state = ST_DONE;
			end
			ST_DONE: begin
				if (wr_cmd && wdata16 == CLEAR_AVAIL_VAL) begin
					nxt_avail = 1'b0;
					// failed result locks out reruns until reset
					nxt_state = fail_ff ? ST_DONE : ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
		nxt_busy = (nxt_state == ST_RUN) || (nxt_state == ST_POST);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff     <= ST_IDLE;
			bus_ctrl_ff  <= RESET_VAL[15:0];
			avail_ff     <= 1'b0;
			fail_ff      <= 1'b0;
			code_ff      <= RES_PASS;
			unit_ff      <= 3'h0;
			u_start_pend <= 1'b0;
			tmo_ff       <= RESET_VAL;
			busy_ff      <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			bus_ctrl_ff  <= nxt_bus_ctrl;
			avail_ff     <= nxt_avail;
			fail_ff      <= nxt_fail;
			code_ff      <= nxt_code;
			unit_ff      <= nxt_unit;
			u_start_pend <= nxt_pend;
			tmo_ff       <= nxt_tmo;
			busy_ff      <= nxt_busy;
		end
	end

	// combinational wait keeps every access at exactly one wait state
	assign avs_waitrequest = req && !ack_ff;
	assign avs_readdata    = rdata_ff;
	assign avs_response    = resp_ff;
	assign test_busy       = busy_ff;
endmodule
`default_nettype wire

// [src/lst_unit_check.sv]
// one unit check: lfsr signature over a fixed number of cycles
// assumes start is a single pulse; done held until next start, ok until the next done
`timescale 1ns/1ps
`default_nettype none
module lst_unit_check
	import lst_pkg::*;
#(
	parameter logic [15:0] SEED = 16'hace1
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic reset_n,
	// control
	input  wire logic start,
	input  wire logic force_fault,
	// result
	output logic      done,
	output logic      ok
);
	logic [15:0] lfsr_ff, nxt_lfsr;
	logic [4:0]  cnt_ff, nxt_cnt;
	logic        run_ff, nxt_run;
	logic        done_ff, nxt_done;
	logic        ok_ff, nxt_ok;
	logic [15:0] golden;

	// signature of the seed after UNIT_CYCLES steps, constant per instance
	function automatic logic [15:0] step(input logic [15:0] v);
		step = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic [15:0] sig(input logic [15:0] s);
		logic [15:0] v;
		v = s;
		for (int i = 0; i < UNIT_CYCLES; i++) begin
			v = step(v);
		end
		sig = v;
	endfunction
	assign golden = sig(SEED);

	always_comb begin
		nxt_lfsr = lfsr_ff;
		nxt_cnt  = cnt_ff;
		nxt_run  = run_ff;
		nxt_done = done_ff;
		nxt_ok   = ok_ff;
		if (start) begin
			nxt_lfsr = SEED ^ {15'h0, force_fault};
			nxt_cnt  = 5'h0;
			nxt_run  = 1'b1;
			nxt_done = 1'b0;
		end else if (run_ff) begin
			nxt_lfsr = step(lfsr_ff);
			nxt_cnt  = cnt_ff + 5'h1;
			if (cnt_ff == 5'(UNIT_CYCLES - 1)) begin
				nxt_run  = 1'b0;
				nxt_done = 1'b1;
				nxt_ok   = (step(lfsr_ff) == golden);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			lfsr_ff <= 16'h0;
			cnt_ff  <= 5'h0;
			run_ff  <= 1'b0;
			done_ff <= 1'b0;
			ok_ff   <= 1'b0;
		end else begin
			lfsr_ff <= nxt_lfsr;
			cnt_ff  <= nxt_cnt;
			run_ff  <= nxt_run;
			done_ff <= nxt_done;
			ok_ff   <= nxt_ok;
		end
	end

	assign done = done_ff;
	assign ok   = ok_ff;
endmodule
`default_nettype wire

// [testbench/lst_host_model.sv]
// host model: reset driver and avalon-mm master
// assumes its tasks are called from one bench process
`timescale 1ns/1ps
`default_nettype none
module lst_host_model
	import lst_pkg::*;
(
	// clock
	input wire logic          ref_clk,
	// reset and bus master
	output logic              reset_n,
	output logic [ADDR_W-1:0] avs_address,
	output logic              avs_read,
	output logic              avs_write,
	output logic [31:0]       avs_writedata,
	output logic [3:0]        avs_byteenable,
	input wire logic [31:0]   avs_readdata,
	input wire logic          avs_waitrequest
);
	logic [31:0] rdat;
	logic        ok;
	initial begin
		reset_n = 1'b0;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
	end
	task automatic hw_reset();
		reset_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
	endtask
	// request held until waitrequest seen low, for at most 16 cycles
	task automatic acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		ok = 1'b0;
		for (n = 0; n < 16 && !ok; n++) begin
			@(posedge ref_clk);
			ok = avs_waitrequest === 1'b0;
		end
		rdat = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic start();
		acc(1'b1, OFS_BUS_CTRL, 32'h10);
		acc(1'b1, OFS_PRIM_CMD, 32'h0500);
	endtask
	task automatic poll();
		int n;
		rdat = 32'h0;
		for (n = 0; n < 600 && rdat[AVAIL_BIT] !== 1'b1 && ok; n++) begin
			acc(1'b0, OFS_PRIM_CMD, 32'h0);
		end
	endtask
	task automatic clear();
		acc(1'b1, OFS_PRIM_CMD, {16'h0, CLEAR_AVAIL_VAL});
	endtask
endmodule
`default_nettype wire

// [testbench/lst_self_test_checker.sv]
// port assertions for the self-test sequencer
// assumes one clock and reset_n async active low
`timescale 1ns/1ps
`default_nettype none
module lst_checker
	import lst_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = 1000
) (
	// clock and reset
	input wire logic              ref_clk,
	input wire logic              reset_n,
	// bus
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic [31:0]       avs_readdata,
	input wire logic              avs_waitrequest,
	input wire logic [1:0]        avs_response,
	// test pin
	input wire logic              test_busy
);
	logic [31:0] busy_ff;
	logic [31:0] nxt_busy;
	logic        ack;
	logic        pr;
	logic        mapped;
	assign ack = avs_read && !avs_waitrequest;
	assign pr = ack && avs_address == OFS_PRIM_CMD && avs_readdata[AVAIL_BIT];
	assign mapped = avs_address == OFS_PRIM_CMD || avs_address == OFS_BUS_CTRL;
	// cycles spent in one test run
	always_comb begin
		nxt_busy = test_busy ? busy_ff + 32'h1 : 32'h0;
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_ff <= 32'h0;
		end else begin
			busy_ff <= nxt_busy;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("request acked with no wait state");
	a_one_wait: assert property (avs_waitrequest |=> !avs_waitrequest)
		else $error("wait state too long");
	a_test_bound: assert property (busy_ff <= TIMEOUT_CYCLES + 32)
		else $error("test ran past its limit");
	a_fail_code: assert property (pr |-> avs_readdata[FAIL_BIT] == |avs_readdata[3:0])
		else $error("fail bit disagrees with code");
	a_code_range: assert property (pr |-> avs_readdata[3:0] <= RES_DEV)
		else $error("result code out of range");
	a_upper_zero: assert property (ack |-> avs_readdata[31:16] == 16'h0)
		else $error("upper read bits set");
	a_unmapped: assert property (ack && !mapped |-> avs_response == 2'h2 && avs_readdata == 0)
		else $error("unmapped read not refused");
	a_mapped_ok: assert property (ack && mapped |-> avs_response == 2'h0)
		else $error("mapped read refused");
endmodule
bind lst_self_test lst_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
	.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.avs_response(avs_response), .test_busy(test_busy)
);
`default_nettype wire

// [testbench/test_link_controller_self_test.sv]
// self-checking bench for the self-test sequencer
// assumes the host model drives reset and the bus
`timescale 1ns/1ps
`default_nettype none
module test_link_controller_self_test
	import lst_pkg::*;
;
	logic                 ref_clk = 1'b0;
	logic                 reset_n;
	logic [ADDR_W-1:0]    avs_address;
	logic                 avs_read;
	logic                 avs_write;
	logic [31:0]          avs_writedata;
	logic [3:0]           avs_byteenable;
	logic [31:0]          avs_readdata;
	logic                 avs_waitrequest;
	logic [NUM_UNITS-1:0] fault_inject = '0;
	logic                 test_busy;
	int                   failures = 0;
	int                   checks_done = 0;
	always #2.5 ref_clk = !ref_clk;
	lst_host_model u_host (
		.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
	);
	// short limit keeps the run brief
	lst_self_test #(.TIMEOUT_CYCLES(1000)) u_dut (
		.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(),
		.fault_inject(fault_inject), .test_busy(test_busy)
	);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// a hung slave ends the run
	task automatic guard();
		if (!u_host.ok) begin
			failures++;
			results();
		end
	endtask
	task automatic rd_prim();
		u_host.acc(1'b0, OFS_PRIM_CMD, 32'h0);
		guard();
	endtask
	// a flag that never comes ends the run as a failure
	task automatic wait_done();
		u_host.poll();
		guard();
		if (u_host.rdat[AVAIL_BIT] !== 1'b1) begin
			failures++;
			results();
		end
	endtask
	// bus control reset value, unmapped read, request outside test mode
	task automatic t_regs();
		u_host.hw_reset();
		u_host.acc(1'b0, OFS_BUS_CTRL, 32'h0);
		check("bus ctrl reset", u_host.rdat, 32'h0);
		u_host.acc(1'b0, 4'hc, 32'h0);
		check("unmapped data", u_host.rdat, 32'h0);
		u_host.acc(1'b1, OFS_PRIM_CMD, 32'h0500);
		u_host.poll();
		guard();
		check("no mode flag", u_host.rdat & 32'h40, 32'h0);
		check("no mode busy", {31'h0, test_busy}, 32'h0);
	endtask
	// pass, held result, clear, rerun without reset
	task automatic t_pass();
		int k;
		u_host.hw_reset();
		for (k = 0; k < 2; k++) begin
			u_host.start();
			u_host.acc(1'b0, OFS_BUS_CTRL, 32'h0);
			guard();
			check("mode set", u_host.rdat, 32'h10);
			wait_done();
			check("pass result", u_host.rdat & 32'h5f, 32'h40);
			rd_prim();
			check("pass held", u_host.rdat & 32'h5f, 32'h40);
			u_host.clear();
			rd_prim();
			check("flag cleared", u_host.rdat & 32'h40, 32'h0);
		end
	endtask
	// each failing unit, then a rerun that stays locked
	task automatic t_fail();
		int i;
		for (i = 0; i < NUM_UNITS; i++) begin
			u_host.hw_reset();
			fault_inject <= NUM_UNITS'(1 << i);
			u_host.start();
			wait_done();
			check("fail result", u_host.rdat & 32'h5f, 32'h51 + i);
			rd_prim();
			check("fail held", u_host.rdat & 32'h5f, 32'h51 + i);
			u_host.clear();
			u_host.start();
			u_host.poll();
			guard();
			check("rerun locked", u_host.rdat & 32'h40, 32'h0);
			fault_inject <= '0;
		end
		u_host.hw_reset();
	endtask
	initial begin
		t_regs();
		t_pass();
		t_fail();
		results();
	end
endmodule
`default_nettype wire
